// file: hdl/virq_defs.svh
// Constants of the vectored interrupt block: offsets, fields, resets, vectors
`ifndef VIRQ_DEFS_SVH
`define VIRQ_DEFS_SVH

// Register offsets (word index on the plain register port)
`define VIRQ_OFS_SENS      4'h0
`define VIRQ_OFS_STATUS    4'h1
`define VIRQ_OFS_MASK      4'h2
`define VIRQ_OFS_PENDING   4'h3
`define VIRQ_OFS_VECTOR    4'h4

// Reset values
`define VIRQ_SENS_RST      8'h00
`define VIRQ_MASK_RST      8'h00

// Sensitivity field codes
`define VIRQ_SENS_FALL_LOW 2'h0
`define VIRQ_SENS_RISE     2'h1
`define VIRQ_SENS_FALL     2'h2
`define VIRQ_SENS_BOTH     2'h3

// Vector table: reset at top, trap two bytes below, vector n below that
`define VIRQ_VEC_RESET     16'hFFFE
`define VIRQ_VEC_TRAP      16'hFFFC
`define VIRQ_VEC_STEP      16'h0002

// Source numbers
`define VIRQ_SRC_EXT0      4'h1
`define VIRQ_SRC_AT_CMP    4'h8
`define VIRQ_SRC_AT_OVF    4'h9
`define VIRQ_SRC_LT_CAP    4'hA
`define VIRQ_SRC_LT_TB     4'hB
`define VIRQ_SRC_SPI       4'hC

// Halt-wakeup capability per source number 0..13 (bit n = source n)
`define VIRQ_WAKE_MAP      14'h1A1E

`endif

// file: hdl/virq_pkg.sv
// Types of the vectored interrupt block
package virq_pkg;

  typedef enum logic [2:0] {
    VIRQ_IDLE  = 3'b001,
    VIRQ_OFFER = 3'b010,
    VIRQ_ACK   = 3'b100
  } virq_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } virq_bus_t;

  typedef struct packed {
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    logic [3:0] prev;
    logic [3:0] pend;
  } virq_edge_t;

  typedef struct packed {
    virq_state_t state;
    logic [7:0]  sens;
    logic [7:0]  status;
    logic [7:0]  mask;
    logic [3:0]  num;
    logic [15:0] vector;
    logic        wake;
    logic        req;
    logic [7:0]  rdata;
  } virq_core_t;

endpackage : virq_pkg

// file: hdl/virq_ext_lines.sv
// Edge/level detection and pending latches for the four external lines
`timescale 1ns/1ps
`default_nettype none
`include "virq_defs.svh"

module virq_ext_lines
  import virq_pkg::*;
#(
  parameter int PINS = 2
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Pins and enables per line
  input  wire logic [4*PINS-1:0] pin_in,
  input  wire logic [4*PINS-1:0] pin_irq_en,
  // Control from the core logic
  input  wire logic [7:0]        sens,
  input  wire logic [3:0]        clear,
  // Pending requests
  output logic [3:0]             pending
);

  virq_edge_t st_reg;
  virq_edge_t st_next;
  logic [3:0] line;

  always_comb begin
    for (int l = 0; l < 4; l++) begin
      line[l] = 1'b1;
      for (int p = 0; p < PINS; p++) begin
        if (pin_irq_en[l*PINS+p]) begin
          line[l] = line[l] & pin_in[l*PINS+p];
        end
      end
    end
  end

  always_comb begin
    logic [1:0] f;
    logic       cur;
    logic       old;
    logic       hit;
    f   = 2'h0;
    cur = 1'b0;
    old = 1'b0;
    hit = 1'b0;
    st_next = st_reg;
    st_next.sync_a = line;
    st_next.sync_b = st_reg.sync_a;
    st_next.prev   = st_reg.sync_b;
    for (int l = 0; l < 4; l++) begin
      f   = sens[2*l +: 2];
      cur = st_reg.sync_b[l];
      old = st_reg.prev[l];
      case (f)
        `VIRQ_SENS_FALL_LOW: hit = ~cur;
        `VIRQ_SENS_RISE:     hit = cur & ~old;
        `VIRQ_SENS_FALL:     hit = ~cur & old;
        default:             hit = cur ^ old;
      endcase
      // clear on change or fetch; a new event still wins
      if (hit) begin
        st_next.pend[l] = 1'b1;
      end else if (clear[l]) begin
        st_next.pend[l] = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '{sync_a: 4'hF, sync_b: 4'hF, prev: 4'hF, pend: 4'h0};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign pending = st_reg.pend;

endmodule : virq_ext_lines
`default_nettype wire

// file: hdl/virq_top.sv
// Vectored interrupt controller with external line sensitivity
`timescale 1ns/1ps
`default_nettype none
`include "virq_defs.svh"

module virq_top
  import virq_pkg::*;
#(
  parameter int PINS = 2
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // External line pins, PINS per line, line 0 lowest
  input  wire logic [4*PINS-1:0] ext_pin,
  input  wire logic [4*PINS-1:0] ext_pin_irq_en,
  // Peripheral request levels
  input  wire logic              at_cmp_req,
  input  wire logic              at_ovf_req,
  input  wire logic              lt_cap_req,
  input  wire logic              lt_tb_req,
  input  wire logic              spi_req,
  input  wire logic              avd_req,
  // Core side
  input  wire logic              core_int_mask,
  input  wire logic              trap_req,
  input  wire logic              vec_fetch,
  output logic                   irq_req,
  output logic [15:0]            irq_vector,
  output logic [3:0]             irq_num,
  output logic                   halt_wake,
  output logic                   irq_out
);

  virq_core_t st_reg;
  virq_core_t st_next;
  logic [3:0] ext_pend;
  logic [3:0] ext_clear;
  logic [13:0] src;
  logic [3:0] best;
  logic       any;
  logic       wr_sens;
  logic [7:0] events;

  // vector of source n, two bytes per entry
  function automatic logic [15:0] vec_of(input logic [3:0] n);
    vec_of = `VIRQ_VEC_TRAP - (16'({12'h000, n} + 16'h0001) * `VIRQ_VEC_STEP);
  endfunction

  // write gate from the core mask bit
  assign wr_sens = reg_wr && (reg_addr == `VIRQ_OFS_SENS) && core_int_mask;

  // per-line clear when its field changes or when its vector is fetched (ACK)
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      ext_clear[l] = wr_sens && (reg_wdata[2*l +: 2] != st_reg.sens[2*l +: 2]);
      if (st_reg.state == VIRQ_ACK && st_reg.num == (`VIRQ_SRC_EXT0 + 4'(l))) begin
        ext_clear[l] = 1'b1;
      end
    end
  end

  virq_ext_lines #(
    .PINS (PINS)
  ) u_lines (
    .mclk       (mclk),
    .reset      (reset),
    .clk_en     (clk_en),
    .pin_in     (ext_pin),
    .pin_irq_en (ext_pin_irq_en),
    .sens       (st_reg.sens),
    .clear      (ext_clear),
    .pending    (ext_pend)
  );

  // Source vector, index = vector number; 0, 5, 6, 13 unused
  always_comb begin
    src = 14'h0000;
    src[4:1] = ext_pend;
    src[7]   = avd_req;
    src[8]   = at_cmp_req;
    src[9]   = at_ovf_req;
    src[10]  = lt_cap_req;
    src[11]  = lt_tb_req;
    src[12]  = spi_req;
  end

  always_comb begin
    best = 4'h0;
    any  = 1'b0;
    for (int n = 13; n >= 0; n--) begin
      if (src[n]) begin
        best = 4'(n);
        any  = 1'b1;
      end
    end
  end

  // Sticky event bits: lines 0-3, compare, overflow, capture, timebase
  assign events = {lt_tb_req, lt_cap_req, at_ovf_req, at_cmp_req, ext_pend};

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    if (reg_wr) begin
      if (wr_sens) begin
        st_next.sens = reg_wdata;
      end else if (reg_addr == `VIRQ_OFS_STATUS) begin
        st_next.status = st_reg.status & ~reg_wdata;
      end else if (reg_addr == `VIRQ_OFS_MASK) begin
        st_next.mask = reg_wdata;
      end
    end
    // Set wins over a clear in the same cycle
    st_next.status = st_next.status | events;
    if (reg_rd) begin
      if (reg_addr == `VIRQ_OFS_SENS) begin
        st_next.rdata = st_reg.sens;
      end else if (reg_addr == `VIRQ_OFS_STATUS) begin
        st_next.rdata = st_reg.status;
      end else if (reg_addr == `VIRQ_OFS_MASK) begin
        st_next.rdata = st_reg.mask;
      end else if (reg_addr == `VIRQ_OFS_PENDING) begin
        st_next.rdata = {4'h0, ext_pend};
      end else if (reg_addr == `VIRQ_OFS_VECTOR) begin
        st_next.rdata = {4'h0, st_reg.num};
      end else begin
        st_next.rdata = 8'h00;
      end
    end
    // halt wakeup map; wakes even while masked
    st_next.wake = |(src & `VIRQ_WAKE_MAP);
    case (st_reg.state)
      VIRQ_IDLE: begin
        st_next.req = 1'b0;
        if (trap_req) begin
          st_next.vector = `VIRQ_VEC_TRAP;
          st_next.num    = 4'hF;
          st_next.req    = 1'b1;
          st_next.state  = VIRQ_OFFER;
        end else if (any && !core_int_mask) begin
          st_next.vector = vec_of(best);
          st_next.num    = best;
          st_next.req    = 1'b1;
          st_next.state  = VIRQ_OFFER;
        end
      end
      VIRQ_OFFER: begin
        // Keep offering until the core fetches it; a non-trap offer tracks the best request and goes idle if no unmasked request is left
        if (vec_fetch) begin
          st_next.req   = 1'b0;
          st_next.state = VIRQ_ACK;
        end else if (st_reg.num != 4'hF) begin
          if (any && !core_int_mask) begin
            st_next.vector = vec_of(best);
            st_next.num    = best;
          end else begin
            st_next.req   = 1'b0;
            st_next.state = VIRQ_IDLE;
          end
        end
      end
      VIRQ_ACK: begin
        st_next.state = VIRQ_IDLE;
      end
      default: begin
        st_next.state = VIRQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_reg <= '{state: VIRQ_IDLE, sens: `VIRQ_SENS_RST, status: 8'h00, mask: `VIRQ_MASK_RST,
                 num: 4'h0, vector: `VIRQ_VEC_RESET, wake: 1'b0, req: 1'b0, rdata: 8'h00};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata  = st_reg.rdata;
  assign irq_req    = st_reg.req;
  assign irq_vector = st_reg.vector;
  assign irq_num    = st_reg.num;
  assign halt_wake  = st_reg.wake;
  assign irq_out    = |(st_reg.status & st_reg.mask);

endmodule : virq_top
`default_nettype wire

// file: tb/virq_core_model.sv
// Core model: holds the interrupt mask and fetches offered vectors
`timescale 1ns/1ps
`default_nettype none
module virq_core_model (
  // Clock, reset, bench commands
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        mask_cmd,
  input  wire logic        slow,
  // Vector link
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic [3:0]  irq_num,
  output logic             core_int_mask,
  output logic             vec_fetch,
  output int               fetch_cnt,
  output logic [15:0]      got_vec,
  output logic [3:0]       got_num
);
  int wait_cnt;
  assign core_int_mask = mask_cmd;
  // Slow mode lets the offer stand five cycles before the fetch
  always_ff @(posedge mclk) begin
    if (reset) begin
      vec_fetch <= 1'b0;
      wait_cnt <= 0;
      fetch_cnt <= 0;
    end else if (vec_fetch) begin
      vec_fetch <= 1'b0;
      fetch_cnt <= fetch_cnt + 1;
      got_vec <= irq_vector;
      got_num <= irq_num;
    end else if (irq_req && wait_cnt >= (slow ? 5 : 0)) begin
      vec_fetch <= 1'b1;
      wait_cnt <= 0;
    end else begin
      wait_cnt <= irq_req ? wait_cnt + 1 : 0;
    end
  end
endmodule // virq_core_model
`default_nettype wire

// file: tb/virq_top_checker.sv
// Port assertions of the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module virq_top_checker (
  // Clock, reset, register port
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  // Requests and core side
  input wire logic        at_ovf_req,
  input wire logic        core_int_mask,
  input wire logic        trap_req,
  input wire logic        vec_fetch,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [3:0]  irq_num,
  input wire logic        halt_wake
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_quiet;
    (core_int_mask && !trap_req) [*3];
  endsequence
  sequence s_fetch;
    vec_fetch && irq_req;
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_vec_step: assert property (irq_req && irq_num != 4'hF |->
    irq_vector == 16'hFFFA - {11'h000, irq_num, 1'b0}) else $error("vector step");
  a_trap_vec: assert property (irq_req && irq_num == 4'hF |-> irq_vector == 16'hFFFC)
    else $error("trap vector");
  a_fetch_drop: assert property (s_fetch |=> !irq_req) else $error("offer after fetch");
  a_trap_offer: assert property ($rose(trap_req) && !irq_req |->
    ##[1:2] (irq_req && irq_num == 4'hF)) else $error("trap not offered");
  a_masked_quiet: assert property (s_quiet |-> !irq_req) else $error("offer while masked");
  a_ovf_wake: assert property (at_ovf_req [*3] |-> halt_wake) else $error("no wake");
  a_num_legal: assert property (irq_req |-> irq_num inside {[4'h1:4'h4], [4'h7:4'hC], 4'hF})
    else $error("bad number");
endmodule // virq_top_checker
bind virq_top virq_top_checker u_virq_top_checker (.mclk, .reset, .reg_rd, .reg_rdata, .at_ovf_req,
  .core_int_mask, .trap_req, .vec_fetch, .irq_req, .irq_vector, .irq_num, .halt_wake);
`default_nettype wire

// file: tb/test_vectored_irq_with_edge_select.sv
// Self-checking bench of the vectored interrupt block
`timescale 1ns/1ps
`default_nettype none
module test_vectored_irq_with_edge_select;
  logic mclk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, trap_req = 1'b0, mask_cmd = 1'b1, slow = 1'b0;
  logic at_cmp_req = 1'b0, at_ovf_req = 1'b0, lt_cap_req = 1'b0, lt_tb_req = 1'b0, spi_req = 1'b0, avd_req = 1'b0;
  logic core_int_mask, vec_fetch, irq_req, halt_wake, irq_out;
  logic clk_en = 1'b1;
  logic [3:0] reg_addr = 4'h0, irq_num, got_num;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, ext_pin = 8'hFF, ext_pin_irq_en = 8'h03;
  logic [15:0] irq_vector, got_vec;
  int fetch_cnt, num_errors = 0, checks = 0, seed = 32'hA74A_62CD, sens_m = 0, v, n;
  virq_top u_virq_top (.mclk, .reset, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_pin, .ext_pin_irq_en, .at_cmp_req, .at_ovf_req, .lt_cap_req, .lt_tb_req, .spi_req, .avd_req,
    .core_int_mask, .trap_req, .vec_fetch, .irq_req, .irq_vector, .irq_num, .halt_wake, .irq_out);
  virq_core_model u_virq_core_model (.mclk, .reset, .mask_cmd, .slow, .irq_req, .irq_vector, .irq_num,
    .core_int_mask, .vec_fetch, .fetch_cnt, .got_vec, .got_num);
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (exp !== got) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp(name, {8'h00, exp}, {8'h00, reg_rdata});
  endtask
  // Only pin 1 of line 0 moves, pin 0 stays high beside it
  task automatic pin(input logic lvl);
    @(posedge mclk);
    ext_pin[1] <= lvl;
    repeat (5) @(posedge mclk);
  endtask
  task automatic reqs(input logic [5:0] r);
    {avd_req, spi_req, lt_tb_req, lt_cap_req, at_ovf_req, at_cmp_req} <= r;
  endtask
  task automatic take(input int e);
    int c0;
    c0 = fetch_cnt;
    repeat (40) if (fetch_cnt == c0) @(posedge mclk);
    cmp("fetch", 16'(c0 + 1), 16'(fetch_cnt));
    cmp("num", 16'(e), {12'h000, got_num});
    cmp("vector", (e == 15) ? 16'hFFFC : 16'(16'hFFFA - 2 * e), got_vec);
  endtask
  task automatic stop_test();
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #(25 * 4000);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rdc("sens", 4'h0, 8'h00);
    rdc("unmapped", 4'hF, 8'h00);
    wr(4'h2, 8'hF0);
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      @(posedge mclk);
      mask_cmd <= v[8];
      wr(4'h0, v[7:0]);
      if (v[8]) sens_m = v[7:0];
      rdc("sens", 4'h0, 8'(sens_m));
    end
    @(posedge mclk);
    mask_cmd <= 1'b1;
    // Mid-run reset brings sensitivity and mask back to zero
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdc("sens", 4'h0, 8'h00);
    rdc("mask", 4'h2, 8'h00);
    wr(4'h2, 8'hF0);
    rdc("mask", 4'h2, 8'hF0);
    // A write while the clock enable is low must not land
    @(posedge mclk);
    clk_en <= 1'b0;
    wr(4'h0, 8'h55);
    clk_en <= 1'b1;
    rdc("sens", 4'h0, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(4'h0, 8'(c ^ 1));
      wr(4'h0, 8'(c));
      repeat (4) @(posedge mclk);
      rdc("pending", 4'h3, 8'h00);
      pin(1'b0);
      rdc("pending", 4'h3, 8'(c != 1));
      wr(4'h0, (c == 2) ? 8'h03 : 8'h02);
      // A low level under code 00 may relatch at the change edge
      if (c != 0) rdc("pending", 4'h3, 8'h00);
      wr(4'h0, 8'(c));
      pin(1'b1);
      rdc("pending", 4'h3, 8'(c != 2));
    end
    wr(4'h0, 8'h02);
    pin(1'b0);
    mask_cmd <= 1'b0;
    take(1);
    mask_cmd <= 1'b1;
    pin(1'b1);
    rdc("pending", 4'h3, 8'h00);
    wr(4'h1, 8'hFF);
    for (int i = 0; i < 6; i++) begin
      n = (i == 5) ? 7 : 8 + i;
      slow <= i[0];
      reqs(6'(1 << i));
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      cmp("wake", 16'(n inside {9, 11, 12}), {15'h0000, halt_wake});
      cmp("irq_out", 16'(i < 4), {15'h0000, irq_out});
      rdc("status", 4'h1, 8'(i < 4 ? 1 << (i + 4) : 0));
      @(posedge mclk);
      mask_cmd <= 1'b0;
      take(n);
      reqs(6'h00);
      mask_cmd <= 1'b1;
      wr(4'h1, 8'hFF);
      @(negedge mclk);
      cmp("irq_out", 16'h0000, {15'h0000, irq_out});
      rdc("last_num", 4'h4, 8'(n));
    end
    reqs(6'h3F);
    repeat (3) @(posedge mclk);
    trap_req <= 1'b1;
    mask_cmd <= 1'b0;
    take(15);
    trap_req <= 1'b0;
    take(7);
    reqs(6'h00);
    mask_cmd <= 1'b1;
    stop_test();
  end
endmodule // test_vectored_irq_with_edge_select
`default_nettype wire
